// file: hw/logic_tile_cfg.svh
// logic tile constants: register offsets, field positions, reset values
// assumes a 32-bit avalon-mm slave with byte addresses
//
// Function
// - each cell has a 4-input table, carry logic and one storage element
// - four cells in two slices, two cells per slice
// - each table works as logic or as 16x1 synchronous ram
// - slice tables combine into 16x2, 32x1 or 16x1 dual-port ram
// - each table works as a 16-stage shift register
// - storage element is an edge flip-flop or a level latch
// - storage data is cell output (table or xor sum) or direct slice input
// - init_force loads each storage element with its configured initial value
// - opposite_force loads the complement of the initial value
// - both forces act synchronously unless configured asynchronous
// - clock, enable and forces each invertible, shared within a slice
// - five_input_mux per slice selects between its two table outputs
// - six_input_mux selects one of the two five_input_mux outputs
// - four direct feedthrough paths, one per cell
// - two carry chains, one per slice, two bits each
// - per-cell xor forms a full adder sum with the carry
// - dedicated and gate feeds partial products into the carry
// - carry path cascades tables into wide functions
// - two tristate bus drivers, each with own data and control
`ifndef LOGIC_TILE_CFG_SVH
`define LOGIC_TILE_CFG_SVH

// byte offsets
`define OFS_TABLE0     5'h00
`define OFS_TABLE1     5'h04
`define OFS_TABLE2     5'h08
`define OFS_TABLE3     5'h0c
`define OFS_SLICE0     5'h10
`define OFS_SLICE1     5'h14
`define OFS_STATUS     5'h18

// slice configuration fields
`define SC_MODE_LSB    0
`define SC_MODE_MSB    2
`define SC_LATCH       3
`define SC_BYPASS      4
`define SC_ASYNC       5
`define SC_INV_CLK     6
`define SC_INV_CE      7
`define SC_INV_INIT    8
`define SC_INV_OPP     9
`define SC_INIT0       10
`define SC_INIT1       11
`define SC_XOR_EN      12
`define SC_AND_EN      13
`define SC_WIDTH       14

// reset values
`define TABLE_RST      16'h0000
`define SLICE_RST      14'h0000

`endif

// file: hw/logic_tile_pkg.sv
// types of the logic tile
// assumes logic_tile_cfg.svh on the include path
`include "logic_tile_cfg.svh"

package logic_tile_pkg;

   typedef enum logic [2:0] {
      MODE_LOGIC  = 3'b000,
      MODE_RAM16  = 3'b001,
      MODE_RAM16X2 = 3'b010,
      MODE_RAM32  = 3'b011,
      MODE_DUAL   = 3'b100,
      MODE_SHIFT  = 3'b101
   } lut_mode_t;

   typedef struct packed {
      logic [3:0][15:0]          table_r;
      logic [1:0][`SC_WIDTH-1:0] slice_cfg_r;
      logic [1:0]                sclk_prev_r;
      logic [3:0]                q_r;
      logic [3:0]                comb_r;
      logic [3:0]                feed_r;
      logic [1:0]                cout_r;
      logic [1:0]                f5_r;
      logic                      f6_r;
      logic [1:0]                bus_r;
      logic [1:0]                bus_drv_n_r;
      logic                      wait_r;
      logic [31:0]               rdata_r;
   } tile_state_t;

endpackage

// file: hw/logic_tile.sv
// configurable logic tile: four cells in two slices, registered outputs
// assumes slice pins synchronous to mclk_in; slice clocks are sampled levels
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "logic_tile_cfg.svh"

module logic_tile
   import logic_tile_pkg::*;
(
   // clock and reset
   input  wire logic             mclk_in,
   input  wire logic             nrst_in,
   // avalon-mm slave
   input  wire logic [4:0]       avs_address_in,
   input  wire logic             avs_read_in,
   input  wire logic             avs_write_in,
   input  wire logic [31:0]      avs_writedata_in,
   input  wire logic [3:0]       avs_byteenable_in,
   output logic      [31:0]      avs_readdata_out,
   output logic                  avs_waitrequest_out,
   // cell inputs
   input  wire logic [3:0][3:0]  lut_addr_in,
   input  wire logic [3:0]       bypass_in,
   // slice controls
   input  wire logic [1:0]       slice_clk_in,
   input  wire logic [1:0]       slice_ce_in,
   input  wire logic [1:0]       init_force_in,
   input  wire logic [1:0]       opposite_force_in,
   input  wire logic [1:0]       ram_we_in,
   input  wire logic [1:0]       carry_in,
   input  wire logic [1:0]       five_sel_in,
   input  wire logic             six_sel_in,
   // tristate bus drivers
   input  wire logic [1:0]       bus_data_in,
   input  wire logic [1:0]       bus_tri_in,
   input  wire logic [1:0]       hbus_in,
   // cell outputs
   output logic      [3:0]       comb_out,
   output logic      [3:0]       q_out,
   output logic      [3:0]       feed_out,
   output logic      [1:0]       carry_out,
   output logic      [1:0]       five_input_mux_out,
   output logic                  six_input_mux_out,
   output logic      [1:0]       bus_out,
   output logic      [1:0]       bus_drv_n_out
);

   tile_state_t st;
   tile_state_t nxt;

   function automatic logic [31:0] merge_be(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] read_word(input tile_state_t s,
                                             input logic [4:0]  a,
                                             input logic [1:0]  hb);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (a)
         `OFS_TABLE0: r = {16'h0000, s.table_r[0]};
         `OFS_TABLE1: r = {16'h0000, s.table_r[1]};
         `OFS_TABLE2: r = {16'h0000, s.table_r[2]};
         `OFS_TABLE3: r = {16'h0000, s.table_r[3]};
         `OFS_SLICE0: r = {18'h00000, s.slice_cfg_r[0]};
         `OFS_SLICE1: r = {18'h00000, s.slice_cfg_r[1]};
         `OFS_STATUS: r = {24'h000000, hb, s.cout_r, s.q_r};
         default:     r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   // =========================================================
   // next state
   always_comb begin
      logic [3:0]  lut_o;
      logic [3:0]  sum;
      logic [3:0]  cell_o;
      logic [3:0]  d;
      logic [3:0]  raddr;
      logic [3:0]  waddr;
      logic        ci;
      logic        di;
      logic        g;
      logic        edge_act;
      logic        ce;
      logic        ini;
      logic        opp;
      logic        iv;
      logic        hit;
      logic [31:0] w;
      lut_mode_t   m;
      lut_o    = '0;
      sum      = '0;
      cell_o   = '0;
      d        = '0;
      raddr    = '0;
      waddr    = '0;
      ci       = 1'b0;
      di       = 1'b0;
      g        = 1'b0;
      edge_act = 1'b0;
      ce       = 1'b0;
      ini      = 1'b0;
      opp      = 1'b0;
      iv       = 1'b0;
      hit      = 1'b0;
      w        = '0;
      m        = MODE_LOGIC;
      nxt      = st;

      // =========================================================
      // table reads, combinational
      for (int c = 0; c < 4; c++) begin
         m = lut_mode_t'(st.slice_cfg_r[c/2][`SC_MODE_MSB:`SC_MODE_LSB]);
         unique case (m)
            // 16x2 and 32x1 modes read both tables at the first address
            MODE_RAM16X2, MODE_RAM32: raddr = lut_addr_in[(c/2)*2];
            default:                  raddr = lut_addr_in[c];
         endcase
         lut_o[c] = st.table_r[c][raddr];
      end

      // =========================================================
      // slice carry chains and cell outputs
      // two slices, two cells
      for (int s = 0; s < 2; s++) begin
         // one chain per slice, two bits
         ci = carry_in[s];
         for (int j = 0; j < 2; j++) begin
            // and gate feeds partial product as carry generate
            di = st.slice_cfg_r[s][`SC_AND_EN] ?
                 (lut_addr_in[s*2+j][0] & lut_addr_in[s*2+j][1]) : bypass_in[s*2+j];
            // xor sum for a full adder
            sum[s*2+j] = lut_o[s*2+j] ^ ci;
            ci = lut_o[s*2+j] ? ci : di;
            // table feeds cell output and storage
            cell_o[s*2+j] = st.slice_cfg_r[s][`SC_XOR_EN] ? sum[s*2+j] : lut_o[s*2+j];
            d[s*2+j] = st.slice_cfg_r[s][`SC_BYPASS] ? bypass_in[s*2+j] : cell_o[s*2+j];
         end
         nxt.cout_r[s] = ci;
         nxt.f5_r[s] = five_sel_in[s] ? lut_o[s*2+1] : lut_o[s*2];
      end
      nxt.f6_r   = six_sel_in ? nxt.f5_r[1] : nxt.f5_r[0];
      nxt.comb_r = cell_o;
      nxt.feed_r = bypass_in;

      // =========================================================
      // slice clocking, storage, ram and shift writes
      for (int s = 0; s < 2; s++) begin
         // per-slice polarity options shared by both cells
         g        = slice_clk_in[s] ^ st.slice_cfg_r[s][`SC_INV_CLK];
         edge_act = g & ~(st.sclk_prev_r[s] ^ st.slice_cfg_r[s][`SC_INV_CLK]);
         ce       = slice_ce_in[s] ^ st.slice_cfg_r[s][`SC_INV_CE];
         ini      = init_force_in[s] ^ st.slice_cfg_r[s][`SC_INV_INIT];
         opp      = opposite_force_in[s] ^ st.slice_cfg_r[s][`SC_INV_OPP];
         m        = lut_mode_t'(st.slice_cfg_r[s][`SC_MODE_MSB:`SC_MODE_LSB]);
         waddr    = lut_addr_in[s*2];
         for (int j = 0; j < 2; j++) begin
            iv = st.slice_cfg_r[s][`SC_INIT0 + j];
            // asynchronous forces act without waiting for the slice clock
            if (st.slice_cfg_r[s][`SC_ASYNC] && (ini || opp)) begin
               nxt.q_r[s*2+j] = ini ? iv : ~iv;
            // latch follows gate level, flip-flop the active edge
            end else if (st.slice_cfg_r[s][`SC_LATCH] ? g : edge_act) begin
               if (ini) begin
                  nxt.q_r[s*2+j] = iv;
               end else if (opp) begin
                  nxt.q_r[s*2+j] = ~iv;
               end else if (ce) begin
                  nxt.q_r[s*2+j] = d[s*2+j];
               end
            end
         end
         if (edge_act && ram_we_in[s]) begin
            unique case (m)
               MODE_RAM16: begin
                  nxt.table_r[s*2][lut_addr_in[s*2]]       = bypass_in[s*2];
                  nxt.table_r[s*2+1][lut_addr_in[s*2+1]]   = bypass_in[s*2+1];
               end
               MODE_RAM16X2: begin
                  nxt.table_r[s*2][waddr]   = bypass_in[s*2];
                  nxt.table_r[s*2+1][waddr] = bypass_in[s*2+1];
               end
               // 32x1, five_sel picks the upper half
               MODE_RAM32: begin
                  nxt.table_r[s*2 + (five_sel_in[s] ? 1 : 0)][waddr] = bypass_in[s*2];
               end
               // dual port, second table mirrors and reads own address
               MODE_DUAL: begin
                  nxt.table_r[s*2][waddr]   = bypass_in[s*2];
                  nxt.table_r[s*2+1][waddr] = bypass_in[s*2];
               end
               // shift one stage, stage 0 newest
               MODE_SHIFT: begin
                  nxt.table_r[s*2]   = {st.table_r[s*2][14:0], bypass_in[s*2]};
                  nxt.table_r[s*2+1] = {st.table_r[s*2+1][14:0], bypass_in[s*2+1]};
               end
               default: begin
               end
            endcase
         end
      end
      nxt.sclk_prev_r = slice_clk_in;

      // =========================================================
      // tristate drivers, enable low while driving
      nxt.bus_r       = bus_data_in;
      nxt.bus_drv_n_r = bus_tri_in;

      // =========================================================
      // avalon slave: one wait cycle, then completion
      hit = avs_read_in | avs_write_in;
      nxt.wait_r = ~(hit & st.wait_r);
      if (hit && st.wait_r) begin
         nxt.rdata_r = read_word(st, avs_address_in, hbus_in);
      end
      // bus write wins over a same-cycle slice write to a table
      if (avs_write_in && !st.wait_r) begin
         w = merge_be(read_word(st, avs_address_in, hbus_in), avs_writedata_in,
                      avs_byteenable_in);
         unique case (avs_address_in)
            `OFS_TABLE0: nxt.table_r[0] = w[15:0];
            `OFS_TABLE1: nxt.table_r[1] = w[15:0];
            `OFS_TABLE2: nxt.table_r[2] = w[15:0];
            `OFS_TABLE3: nxt.table_r[3] = w[15:0];
            `OFS_SLICE0: nxt.slice_cfg_r[0] = w[`SC_WIDTH-1:0];
            `OFS_SLICE1: nxt.slice_cfg_r[1] = w[`SC_WIDTH-1:0];
            default: begin
            end
         endcase
      end
   end

   // =========================================================
   // state register
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         st                <= '0;
         st.table_r        <= {4{`TABLE_RST}};
         st.slice_cfg_r    <= {2{`SLICE_RST}};
         st.wait_r         <= 1'b1;
         st.bus_drv_n_r    <= 2'b11;
      end else begin
         st <= nxt;
      end
   end

   assign avs_readdata_out    = st.rdata_r;
   assign avs_waitrequest_out = st.wait_r;
   assign comb_out            = st.comb_r;
   assign q_out               = st.q_r;
   assign feed_out            = st.feed_r;
   assign carry_out           = st.cout_r;
   assign five_input_mux_out  = st.f5_r;
   assign six_input_mux_out   = st.f6_r;
   assign bus_out             = st.bus_r;
   assign bus_drv_n_out       = st.bus_drv_n_r;

endmodule
`default_nettype wire

// file: sim/logic_tile_monitor.sv
// checker for the logic tile ports, bound onto logic_tile
// assumes one clock domain and synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module logic_tile_monitor (
   input wire logic       mclk_in,
   input wire logic       nrst_in,
   input wire logic       avs_read_in,
   input wire logic       avs_write_in,
   input wire logic       avs_waitrequest_out,
   input wire logic [3:0] bypass_in,
   input wire logic [1:0] five_sel_in,
   input wire logic       six_sel_in,
   input wire logic [1:0] bus_data_in,
   input wire logic [1:0] bus_tri_in,
   input wire logic [3:0] comb_out,
   input wire logic [3:0] feed_out,
   input wire logic [1:0] five_input_mux_out,
   input wire logic       six_input_mux_out,
   input wire logic [1:0] bus_out,
   input wire logic [1:0] bus_drv_n_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   // ==========================================
   // register bus handshake
   sequence s_req;
      (avs_read_in || avs_write_in) && avs_waitrequest_out;
   endsequence
   sequence s_ans;
      !avs_waitrequest_out ##1 avs_waitrequest_out;
   endsequence
   AST_ANSWER: assert property (s_req |=> s_ans)
      else $error("request not answered for exactly one cycle");
   AST_IDLE: assert property (!avs_read_in && !avs_write_in |=> avs_waitrequest_out)
      else $error("waitrequest low without a request");
   // reset must win even though the default disable would mask it
   AST_RESET: assert property (disable iff (1'b0)
      !nrst_in |=> avs_waitrequest_out && bus_drv_n_out == 2'h3)
      else $error("outputs not at reset level");
   // ==========================================
   // datapath
   AST_FEED: assert property ($past(nrst_in) |-> feed_out == $past(bypass_in))
      else $error("feedthrough differs from delayed input");
   AST_DRV: assert property ($past(nrst_in) |-> bus_drv_n_out == $past(bus_tri_in))
      else $error("driver enable differs from delayed control");
   AST_BUSDATA: assert property ($past(nrst_in) && bus_drv_n_out != 2'h3
      |-> bus_out == $past(bus_data_in))
      else $error("driver data differs from delayed input");
   AST_MUX5: assert property ($past(nrst_in) |-> five_input_mux_out ==
      {($past(five_sel_in[1]) ? comb_out[3] : comb_out[2]),
       ($past(five_sel_in[0]) ? comb_out[1] : comb_out[0])})
      else $error("five input mux picks wrong cell");
   AST_MUX6: assert property ($past(nrst_in)
      |-> six_input_mux_out == five_input_mux_out[$past(six_sel_in)])
      else $error("six input mux picks wrong slice");
endmodule

bind logic_tile logic_tile_monitor i_logic_tile_monitor (.mclk_in, .nrst_in, .avs_read_in,
   .avs_write_in, .avs_waitrequest_out, .bypass_in, .five_sel_in, .six_sel_in, .bus_data_in,
   .bus_tri_in, .comb_out, .feed_out, .five_input_mux_out, .six_input_mux_out, .bus_out,
   .bus_drv_n_out);
`default_nettype wire

// file: sim/hbus_line_model.sv
// horizontal bus line seen by the tile's two drivers
// assumes an enable that is low while the tile drives the line
`timescale 1ns/1ps
`default_nettype none
module hbus_line_model (
   input  wire logic       mclk_in,
   input  wire logic [1:0] line_data_in,
   input  wire logic [1:0] line_off_in,
   output logic      [1:0] line_out
);
   // no keeper: a released line wobbles instead of holding its last value
   logic wobble_r = 1'b0;
   always @(posedge mclk_in) wobble_r <= ~wobble_r;
   always_comb begin
      for (int i = 0; i < 2; i++) line_out[i] = line_off_in[i] ? wobble_r : line_data_in[i];
   end
endmodule
`default_nettype wire

// file: sim/tb_logic_tile.sv
// self-checking bench for logic_tile
// assumes the line model closes the bus drivers back onto hbus_in
`timescale 1ns/1ps
`default_nettype none
module tb_logic_tile;
   logic             mclk_in, nrst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
   logic [4:0]       avs_address_in;
   logic [31:0]      avs_writedata_in, avs_readdata_out, rdat;
   logic [3:0]       avs_byteenable_in, bypass_in, comb_out, q_out, feed_out;
   logic [3:0][3:0]  lut_addr_in;
   logic [1:0]       slice_clk_in, slice_ce_in, init_force_in, opposite_force_in, ram_we_in;
   logic [1:0]       carry_in, five_sel_in, bus_data_in, bus_tri_in, hbus_in;
   logic [1:0]       carry_out, five_input_mux_out, bus_out, bus_drv_n_out;
   logic             six_sel_in, six_input_mux_out;
   int               err_count = 0, n_tests = 0, cyc = 0;
   logic [15:0]      e2 [6] = '{16'h0, 16'h10, 16'h10, 16'h0, 16'h10, 16'h1};
   logic [15:0]      e3 [6] = '{16'h0, 16'h2, 16'h10, 16'h10, 16'h10, 16'h1};

   logic_tile i_logic_tile (.mclk_in, .nrst_in, .avs_address_in, .avs_read_in, .avs_write_in,
      .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
      .lut_addr_in, .bypass_in, .slice_clk_in, .slice_ce_in, .init_force_in,
      .opposite_force_in, .ram_we_in, .carry_in, .five_sel_in, .six_sel_in, .bus_data_in,
      .bus_tri_in, .hbus_in, .comb_out, .q_out, .feed_out, .carry_out, .five_input_mux_out,
      .six_input_mux_out, .bus_out, .bus_drv_n_out);
   hbus_line_model i_hbus_line_model (.mclk_in, .line_data_in(bus_out),
      .line_off_in(bus_drv_n_out), .line_out(hbus_in));

   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   // ceiling far above the few hundred cycles the tests need
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         stop_test();
      end
   end
   // ==========================================
   // tasks
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // request held until waitrequest is sampled low, released after
   task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
      avs_address_in   <= a;
      avs_writedata_in <= d;
      avs_write_in     <= w;
      avs_read_in      <= !w;
      do tick(1); while (avs_waitrequest_out !== 1'b0);
      rdat = avs_readdata_out;
      avs_read_in  <= 1'b0;
      avs_write_in <= 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask
   // slice clock must be seen low between two active edges
   task automatic pulse(input int s);
      slice_clk_in[s] <= 1'b1;
      tick(1);
      slice_clk_in[s] <= 1'b0;
      tick(2);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ==========================================
   // tests
   initial begin
      {avs_read_in, avs_write_in, avs_address_in, avs_writedata_in, lut_addr_in, bypass_in,
       slice_clk_in, init_force_in, opposite_force_in, ram_we_in, carry_in, five_sel_in,
       six_sel_in, bus_data_in, nrst_in} <= '0;
      bus_tri_in <= 2'h3;
      slice_ce_in <= 2'h3;
      avs_byteenable_in <= 4'hf;
      tick(20);
      nrst_in <= 1'b1;
      tick(1);
      for (int i = 0; i < 6; i++) rd(5'(4 * i), 32'h0);
      rd(5'h1c, 32'h0);
      for (int i = 0; i < 4; i++) acc(1'b1, 5'(4 * i), 32'h5a5a_c3a5 + 32'(i));
      for (int i = 0; i < 4; i++) rd(5'(4 * i), 32'h0000_c3a5 + 32'(i));
      lut_addr_in <= '1;
      carry_in <= 2'b01;
      tick(2);
      chk(32'(comb_out), 32'hf);
      chk(32'(carry_out), 32'h1);
      lut_addr_in <= '0;
      carry_in <= 2'b11;
      bypass_in <= 4'h8;
      five_sel_in <= 2'b01;
      six_sel_in <= 1'b1;
      tick(2);
      chk(32'(comb_out), 32'h5);
      chk(32'(carry_out), 32'h2);
      chk(32'({six_input_mux_out, five_input_mux_out}), 32'h6);
      acc(1'b1, 5'h10, 32'h410);
      bypass_in <= 4'h0;
      pulse(0);
      chk(32'(q_out[1:0]), 32'h0);
      bypass_in <= 4'h3;
      pulse(0);
      chk(32'(q_out[1:0]), 32'h3);
      init_force_in <= 2'b01;
      pulse(0);
      chk(32'(q_out[1:0]), 32'h1);
      init_force_in <= 2'b00;
      opposite_force_in <= 2'b01;
      tick(3);
      chk(32'(q_out[1:0]), 32'h1);
      acc(1'b1, 5'h10, 32'h430);
      tick(1);
      chk(32'(q_out[1:0]), 32'h2);
      opposite_force_in <= 2'b00;
      acc(1'b1, 5'h10, 32'h490);
      bypass_in <= 4'h0;
      pulse(0);
      chk(32'(q_out[1:0]), 32'h2);
      slice_ce_in <= 2'b10;
      pulse(0);
      chk(32'(q_out[1:0]), 32'h0);
      slice_ce_in <= 2'b11;
      acc(1'b1, 5'h10, 32'h18);
      slice_clk_in[0] <= 1'b1;
      tick(2);
      // data changes while the gate is open: only a latch follows it
      bypass_in <= 4'h3;
      tick(2);
      chk(32'(q_out[1:0]), 32'h3);
      slice_clk_in[0] <= 1'b0;
      tick(1);
      bypass_in <= 4'h0;
      tick(2);
      chk(32'(q_out[1:0]), 32'h3);
      // inverted slice clock: falling pin is the active edge
      acc(1'b1, 5'h10, 32'h50);
      slice_clk_in[0] <= 1'b1;
      tick(2);
      chk(32'(q_out[1:0]), 32'h3);
      slice_clk_in[0] <= 1'b0;
      tick(2);
      chk(32'(q_out[1:0]), 32'h0);
      acc(1'b1, 5'h10, 32'h510);
      bypass_in <= 4'h3;
      pulse(0);
      chk(32'(q_out[1:0]), 32'h1);
      acc(1'b1, 5'h10, 32'h610);
      pulse(0);
      chk(32'(q_out[1:0]), 32'h2);
      // sum and and-gate carry; picked cell keeps the five mux compare exact
      acc(1'b1, 5'h00, 32'h0);
      acc(1'b1, 5'h04, 32'h0);
      acc(1'b1, 5'h10, 32'h3000);
      bypass_in <= 4'h0;
      lut_addr_in[1] <= 4'h3;
      tick(2);
      chk(32'(comb_out[1:0]), 32'h1);
      chk(32'(carry_out[0]), 32'h1);
      acc(1'b1, 5'h10, 32'h0);
      bus_tri_in <= 2'b01;
      bus_data_in <= 2'b10;
      bypass_in <= 4'h9;
      tick(2);
      chk(32'(feed_out), 32'h9);
      acc(1'b0, 5'h18, 32'h0);
      chk(32'({rdat[7], bus_drv_n_out}), 32'h5);
      lut_addr_in[2] <= 4'h4;
      lut_addr_in[3] <= 4'h1;
      bypass_in <= 4'hc;
      ram_we_in <= 2'b10;
      five_sel_in <= 2'b10;
      for (int m = 0; m < 6; m++) begin
         acc(1'b1, 5'h08, 32'h0);
         acc(1'b1, 5'h0c, 32'h0);
         acc(1'b1, 5'h14, 32'(m));
         pulse(1);
         rd(5'h08, {16'h0, e2[m]});
         rd(5'h0c, {16'h0, e3[m]});
      end
      bypass_in <= 4'h0;
      pulse(1);
      lut_addr_in[2] <= 4'h1;
      tick(2);
      chk(32'(comb_out[2]), 32'h1);
      stop_test();
   end
endmodule
`default_nettype wire
